// file: design/prgbc_params.svh
`ifndef PRGBC_PARAMS_SVH
`define PRGBC_PARAMS_SVH
`define PRGBC_CW 11
`define PRGBC_LOST_CLOCKS 11'h4B0
`define PRGBC_LOST_LINES 11'h2BC
`define PRGBC_ACT_CLK_800 11'h320
`define PRGBC_ACT_CLK_400 11'h190
`define PRGBC_ACT_CLK_480 11'h1E0
`define PRGBC_ACT_LN_480 11'h1E0
`define PRGBC_ACT_LN_240 11'h0F0
`define PRGBC_ACT_LN_272 11'h110
`define PRGBC_HFIX_800 11'h0C2
`define PRGBC_HFIX_400 11'h057
`define PRGBC_HFIX_272 11'h074
`define PRGBC_HFIX_240 11'h068
`define PRGBC_VFIX_800 11'h023
`define PRGBC_VFIX_400 11'h014
`define PRGBC_VFIX_272 11'h01F
`define PRGBC_VFIX_240 11'h014
`define PRGBC_HMIN 11'h014
`define PRGBC_HMAX_800 11'h0DE
`define PRGBC_HMAX_400 11'h07E
`define PRGBC_HMAX_272 11'h0A4
`define PRGBC_HMAX_240 11'h098
`define PRGBC_VMIN_800 11'h00A
`define PRGBC_VMAX_800 11'h023
`define PRGBC_HPER_800 11'h420
`define PRGBC_HPER_400 11'h1FC
`define PRGBC_HPER_272 11'h26E
`define PRGBC_HPER_240 11'h262
`define PRGBC_VPER_800 11'h20D
`define PRGBC_VPER_400 11'h106
`define PRGBC_VPER_272 11'h138
`define PRGBC_VPER_240 11'h106
`define PRGBC_SYNC_W 11'h008
`define PRGBC_VSYNC_W 11'h003
`define PRGBC_DIV_HALF 4'h3
`define PRGBC_LOAD_FRAMES 2'h2
`define PRGBC_STATUS_ADDR 8'h32
`define PRGBC_HPOS_ADDR 8'h08
`define PRGBC_VPOS_ADDR 8'h09
`define PRGBC_HPOS_RST 8'hC2
`define PRGBC_VPOS_RST 8'h23
`define PRGBC_READY_BIT 7
`define PRGBC_INPUT_BIT 1
`define PRGBC_ENABLE_BIT 0
`endif

// file: design/prgbc_pkg.sv
package prgbc_pkg;
  typedef enum logic [1:0] {
    PRGBC_M800X480 = 2'h0,
    PRGBC_M400X240 = 2'h1,
    PRGBC_M480X272 = 2'h2,
    PRGBC_M480X240 = 2'h3
  } prgbc_mode_t;
  typedef enum logic [1:0] {
    PRGBC_SYNC = 2'h0,
    PRGBC_BACK = 2'h1,
    PRGBC_ACTIVE = 2'h3,
    PRGBC_FRONT = 2'h2
  } prgbc_hstate_t;
  typedef logic [5:0] prgbc_colour_t;
endpackage : prgbc_pkg

// file: design/prgbc_link_if.sv
`timescale 1ns/1ps
interface prgbc_link_if;
  import prgbc_pkg::*;
  logic pixelClockIn;
  logic lineSyncN;
  logic frameSyncN;
  logic enableEdge;
  prgbc_colour_t redIn;
  prgbc_colour_t greenIn;
  prgbc_colour_t blueIn;
  modport capture (
    input pixelClockIn, lineSyncN, frameSyncN, enableEdge,
    input redIn, greenIn, blueIn
  );
  modport source (
    output pixelClockIn, lineSyncN, frameSyncN, enableEdge,
    output redIn, greenIn, blueIn
  );
endinterface : prgbc_link_if

// file: design/prgbc_video_source.sv
`timescale 1ns/1ps
`include "prgbc_params.svh"
// Other end: divides core_clk into the pixel clock and drives a
// fixed timing per mode, with syncs active low and the enable
// optionally used for exactly the active width of each line.
module prgbc_video_source
  import prgbc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] modeSel,
  input wire logic useEnable,
  input wire logic [17:0] pixelWord,
  prgbc_link_if.source link
);
  typedef struct packed {
    logic [3:0] div;
    logic pclk;
    logic [10:0] hCnt;
    logic [10:0] vCnt;
    logic hs;
    logic vs;
    logic en;
    logic [17:0] data;
  } prgbc_src_t;
  prgbc_src_t s_q, s_d;
  logic [10:0] hPer, vPer, hAct, hBeg;

  // Mode tables; periods inside the legal windows
  always_comb
  begin
    hPer = `PRGBC_HPER_800;
    vPer = `PRGBC_VPER_800;
    hAct = `PRGBC_ACT_CLK_800;
    hBeg = `PRGBC_HFIX_800;
    case (prgbc_mode_t'(modeSel))
      PRGBC_M400X240:
      begin
        hPer = `PRGBC_HPER_400;
        vPer = `PRGBC_VPER_400;
        hAct = `PRGBC_ACT_CLK_400;
        hBeg = `PRGBC_HFIX_400;
      end
      PRGBC_M480X272:
      begin
        hPer = `PRGBC_HPER_272;
        vPer = `PRGBC_VPER_272;
        hAct = `PRGBC_ACT_CLK_480;
        hBeg = `PRGBC_HFIX_272;
      end
      PRGBC_M480X240:
      begin
        hPer = `PRGBC_HPER_240;
        vPer = `PRGBC_VPER_240;
        hAct = `PRGBC_ACT_CLK_480;
        hBeg = `PRGBC_HFIX_240;
      end
      default:
      begin
      end
    endcase
  end

  // Counters advance on the falling edge of the generated clock
  always_comb
  begin
    s_d = s_q;
    s_d.div = s_q.div + 4'h1;
    if (s_q.div == `PRGBC_DIV_HALF)
    begin
      s_d.div = 4'h0;
      s_d.pclk = ~s_q.pclk;
      if (s_q.pclk)
      begin
        s_d.hCnt = s_q.hCnt + 11'h001;
        if (s_q.hCnt == hPer - 11'h001)
        begin
          s_d.hCnt = 11'h000;
          s_d.vCnt = s_q.vCnt + 11'h001;
          if (s_q.vCnt == vPer - 11'h001)
            s_d.vCnt = 11'h000;
        end
        // Sync widths 8 clocks, 3 lines; edges coincide
        s_d.hs = s_d.hCnt >= `PRGBC_SYNC_W;
        s_d.vs = s_d.vCnt >= `PRGBC_VSYNC_W;
        // Enable exactly active width, on every line: the capture end
        // takes its vertical start from frame sync, not from enable
        s_d.en = useEnable && s_d.hCnt >= hBeg &&
          s_d.hCnt < hBeg + hAct;
        s_d.data = pixelWord;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign link.pixelClockIn = s_q.pclk;
  assign link.lineSyncN = s_q.hs;
  assign link.frameSyncN = s_q.vs;
  assign link.enableEdge = s_q.en;
  assign link.redIn = s_q.data[17:12];
  assign link.greenIn = s_q.data[11:6];
  assign link.blueIn = s_q.data[5:0];
endmodule : prgbc_video_source

// file: design/prgbc_capture.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "prgbc_params.svh"
// What this block does
// - Two straps pick one of four modes
// - Disable strap forces fixed vertical start; fixed horizontal start unless enable is seen
// - 800x480 has 800 clocks, 480 lines
// - Source keeps 800x480 line, frame periods
// - 400x240 active size and periods
// - 480x272 active size and periods
// - 480x240 active size and periods
// - Source keeps sync pulse widths legal
// - Frame sync within ten clocks of line
// - Source gives minimum front porches
// - 800x480 vertical offset 35, or 10-35
// - Enable low, no EEPROM: fixed start
// - Programmable horizontal start 20 to max
// - Enable low with EEPROM: register start
// - EEPROM in use: vertical register start
// - Enable active: start on enable rise
// - Enable lasts exactly the active width
// - Pixel data is three six-bit buses
// - Ready bit shows initial load finished
// - Lost on out-of-range line, frame counts
module prgbc_capture
  import prgbc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic resolutionSelectLo,
  input wire logic resolutionSelectHi,
  input wire logic eepromDisableStrap,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic [17:0] pixelDataOut,
  output logic pixelValid,
  output logic inputLost,
  prgbc_link_if.capture link
);
  typedef struct packed {
    logic [1:0] strapTaken;
    prgbc_mode_t mode;
    logic eeprom_disable_strap;
    logic [4:0] syncA;
    logic [4:0] syncB;
    logic [4:0] prev;
    logic [17:0] pixA;
    logic [17:0] pixB;
    prgbc_hstate_t hState;
    logic [10:0] hCnt;
    logic [10:0] actCnt;
    logic [10:0] vCnt;
    logic [10:0] hLast;
    logic [10:0] vLast;
    logic vActive;
    logic enSeen;
    logic [7:0] hPos;
    logic [7:0] vPos;
    logic [1:0] loadCnt;
    logic ready;
    logic lost;
    logic [7:0] rdata;
    logic [17:0] pix;
    logic valid;
  } prgbc_cap_t;
  prgbc_cap_t s_q, s_d;
  logic [10:0] hAct, vAct, hFix, vFix, hMax, hStart, vStart;
  logic pRise, hsFall, vsFall, enRise, enNow, useReg;

  // Clamp a programmed start into its legal window
  function automatic logic [10:0] prgbc_clamp(input logic [10:0] v,
    input logic [10:0] lo, input logic [10:0] hi);
    prgbc_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : prgbc_clamp

  // Per-mode figures
  always_comb
  begin
    hAct = `PRGBC_ACT_CLK_800;
    vAct = `PRGBC_ACT_LN_480;
    hFix = `PRGBC_HFIX_800;
    vFix = `PRGBC_VFIX_800;
    hMax = `PRGBC_HMAX_800;
    case (s_q.mode)
      PRGBC_M400X240:
      begin
        hAct = `PRGBC_ACT_CLK_400;
        vAct = `PRGBC_ACT_LN_240;
        hFix = `PRGBC_HFIX_400;
        vFix = `PRGBC_VFIX_400;
        hMax = `PRGBC_HMAX_400;
      end
      PRGBC_M480X272:
      begin
        hAct = `PRGBC_ACT_CLK_480;
        vAct = `PRGBC_ACT_LN_272;
        hFix = `PRGBC_HFIX_272;
        vFix = `PRGBC_VFIX_272;
        hMax = `PRGBC_HMAX_272;
      end
      PRGBC_M480X240:
      begin
        hAct = `PRGBC_ACT_CLK_480;
        vAct = `PRGBC_ACT_LN_240;
        hFix = `PRGBC_HFIX_240;
        vFix = `PRGBC_VFIX_240;
        hMax = `PRGBC_HMAX_240;
      end
      default:
      begin
      end
    endcase
  end

  // Start positions: registers only when the EEPROM path is on
  assign useReg = ~s_q.eeprom_disable_strap;
  assign hStart = useReg ? prgbc_clamp({3'h0, s_q.hPos}, `PRGBC_HMIN,
    hMax) : hFix;
  assign vStart = !useReg ? vFix : (s_q.mode == PRGBC_M800X480) ?
    prgbc_clamp({3'h0, s_q.vPos}, `PRGBC_VMIN_800, `PRGBC_VMAX_800) :
    {3'h0, s_q.vPos};

  // Edges seen on the second synchroniser stage only
  assign pRise = s_q.syncB[4] & ~s_q.prev[4];
  assign hsFall = pRise & ~s_q.syncB[3] & s_q.prev[3];
  assign vsFall = pRise & ~s_q.syncB[2] & s_q.prev[2];
  assign enRise = pRise & s_q.syncB[1] & ~s_q.prev[1];
  assign enNow = s_q.syncB[1];

  always_comb
  begin
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.syncA = {link.pixelClockIn, link.lineSyncN, link.frameSyncN,
      link.enableEdge, 1'b0};
    s_d.syncB = s_q.syncA;
    s_d.pixA = {link.redIn, link.greenIn, link.blueIn};
    s_d.pixB = s_q.pixA;
    // Sync levels kept per pixel: they move on the pixel clock fall,
    // so a core-cycle compare would never see their edges at a rise
    s_d.prev[4] = s_q.syncB[4];
    if (pRise)
      s_d.prev[3:0] = s_q.syncB[3:0];
    // Enable type is a board choice: once seen, it rules the start
    s_d.enSeen = s_q.enSeen || enNow;
    // Straps sampled on each of the first three cycles after reset, then held
    if (s_q.strapTaken != 2'h3)
    begin
      s_d.strapTaken = s_q.strapTaken + 2'h1;
      s_d.mode = prgbc_mode_t'({resolutionSelectHi, resolutionSelectLo});
      s_d.eeprom_disable_strap = eepromDisableStrap;
    end
    if (pRise)
    begin
      s_d.hCnt = (s_q.hCnt == `PRGBC_LOST_CLOCKS) ? s_q.hCnt :
        s_q.hCnt + 11'h001;
      case (s_q.hState)
        PRGBC_BACK:
          if ((s_q.enSeen || enNow) ? enRise :
            (s_q.hCnt + 11'h001 >= hStart))
          begin
            s_d.hState = PRGBC_ACTIVE;
            s_d.actCnt = 11'h001;
          end
        PRGBC_ACTIVE:
        begin
          s_d.actCnt = s_q.actCnt + 11'h001;
          if (s_q.actCnt + 11'h001 >= hAct)
            s_d.hState = PRGBC_FRONT;
        end
        default:
        begin
        end
      endcase
      // The start pixel itself is taken, so a line holds hAct pixels
      if ((s_q.hState == PRGBC_ACTIVE || s_d.hState == PRGBC_ACTIVE) &&
        s_q.vActive)
      begin
        s_d.pix = s_q.pixB;
        s_d.valid = 1'b1;
      end
    end
    // Line start: measure and restart
    if (hsFall)
    begin
      s_d.hLast = s_q.hCnt + 11'h001; // Pixel 0 closes the line
      s_d.hCnt = 11'h000;
      s_d.hState = PRGBC_BACK;
      s_d.vCnt = (s_q.vCnt == `PRGBC_LOST_LINES) ? s_q.vCnt :
        s_q.vCnt + 11'h001;
      s_d.vActive = s_q.vCnt + 11'h001 >= vStart &&
        s_q.vCnt + 11'h001 < vStart + vAct;
    end
    if (vsFall)
    begin
      s_d.vLast = s_q.vCnt + 11'h001;
      s_d.vCnt = 11'h000;
      s_d.vActive = 1'b0;
      if (s_q.loadCnt != `PRGBC_LOAD_FRAMES)
        s_d.loadCnt = s_q.loadCnt + 2'h1;
    end
    // Initial load stands for two frames when EEPROM used
    s_d.ready = s_q.eeprom_disable_strap || s_q.loadCnt == `PRGBC_LOAD_FRAMES;
    // Loss covers running counters as well as stopped syncs
    s_d.lost = s_q.hCnt >= `PRGBC_LOST_CLOCKS ||
      s_q.vCnt >= `PRGBC_LOST_LINES ||
      s_q.hLast <= hAct || s_q.vLast <= vAct ||
      s_q.hLast >= `PRGBC_LOST_CLOCKS || s_q.vLast >= `PRGBC_LOST_LINES;
    // Register port; position writes ignored when strap disables
    if (regWrite && !s_q.eeprom_disable_strap)
    begin
      if (regAddr == `PRGBC_HPOS_ADDR)
        s_d.hPos = regWdata;
      else if (regAddr == `PRGBC_VPOS_ADDR)
        s_d.vPos = regWdata;
    end
    s_d.rdata = 8'h00;
    if (regRead)
    begin
      if (regAddr == `PRGBC_STATUS_ADDR)
      begin
        s_d.rdata[`PRGBC_READY_BIT] = s_q.ready;
        s_d.rdata[`PRGBC_INPUT_BIT] = s_q.lost;
        s_d.rdata[`PRGBC_ENABLE_BIT] = enNow;
      end
      else if (regAddr == `PRGBC_HPOS_ADDR)
        s_d.rdata = s_q.hPos;
      else if (regAddr == `PRGBC_VPOS_ADDR)
        s_d.rdata = s_q.vPos;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.hPos <= `PRGBC_HPOS_RST;
      s_q.vPos <= `PRGBC_VPOS_RST;
      s_q.hCnt <= `PRGBC_LOST_CLOCKS; // Lost until syncs arrive
      s_q.hState <= PRGBC_FRONT;
    end
    else
      s_q <= s_d;
  end

  assign regRdata = s_q.rdata;
  assign pixelDataOut = s_q.pix;
  assign pixelValid = s_q.valid;
  assign inputLost = s_q.lost;
endmodule : prgbc_capture

// file: dv/prgbc_link_checker.sv
`timescale 1ns/1ps
// Watches the link between source and capture ends
module prgbc_link_checker
  import prgbc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic pixelClockIn,
  input wire logic lineSyncN,
  input wire logic frameSyncN,
  input wire logic enableEdge,
  input wire prgbc_colour_t redIn,
  input wire prgbc_colour_t greenIn,
  input wire prgbc_colour_t blueIn
);
  logic pixQ;
  logic lineSeen;
  logic [10:0] perCnt;
  logic [10:0] enCnt;
  logic [10:0] syncCnt;
  wire logic pixRise = pixelClockIn && !pixQ;

  // Pixel counts; the first partial line after reset is not judged
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      pixQ <= 1'b0;
      lineSeen <= 1'b0;
      perCnt <= 11'h000;
      enCnt <= 11'h000;
      syncCnt <= 11'h000;
    end
    else
    begin
      pixQ <= pixelClockIn;
      lineSeen <= lineSeen || $fell(lineSyncN);
      perCnt <= $fell(lineSyncN) ? 11'h000 : perCnt + 11'(pixRise);
      enCnt <= $rose(enableEdge) ? 11'h000 : enCnt + 11'(pixRise);
      syncCnt <= $fell(lineSyncN) ? 11'h000
        : syncCnt + 11'(pixRise && !lineSyncN);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_hiHold;
    pixelClockIn[*4] ##1 !pixelClockIn;
  endsequence
  sequence s_loHold;
    !pixelClockIn[*4] ##1 pixelClockIn;
  endsequence
  // One pixel clock of quiet line sync
  sequence s_porch;
    lineSyncN[*8];
  endsequence

  property p_clkHigh;
    $rose(pixelClockIn) |-> s_hiHold;
  endproperty
  property p_clkLow;
    $fell(pixelClockIn) |-> s_loHold;
  endproperty
  property p_syncWidth;
    $rose(lineSyncN) && lineSeen |-> syncCnt >= 11'h005;
  endproperty
  property p_enWidth;
    $fell(enableEdge) |-> enCnt inside {11'h190, 11'h1E0, 11'h320};
  endproperty
  property p_linePer;
    $fell(lineSyncN) && lineSeen |-> perCnt inside {[11'h1EB:11'h440]};
  endproperty
  property p_dataHold;
    pixelClockIn && $past(pixelClockIn)
      |-> $stable({redIn, greenIn, blueIn});
  endproperty
  property p_enQuiet;
    !lineSyncN |-> !enableEdge;
  endproperty
  property p_porch;
    $fell(enableEdge) |-> s_porch ##1 s_porch;
  endproperty

  a_clkHigh: assert property (p_clkHigh)
    else $error("pixel clock high phase is not four cycles");
  a_clkLow: assert property (p_clkLow)
    else $error("pixel clock low phase is not four cycles");
  a_syncWidth: assert property (p_syncWidth)
    else $error("line sync pulse too short");
  a_enWidth: assert property (p_enWidth)
    else $error("enable width is not an active width");
  a_linePer: assert property (p_linePer)
    else $error("line period out of range");
  a_dataHold: assert property (p_dataHold)
    else $error("pixel data moved while pixel clock high");
  a_enQuiet: assert property (p_enQuiet)
    else $error("enable high during line sync");
  a_porch: assert property (p_porch)
    else $error("horizontal front porch too short");
endmodule : prgbc_link_checker

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk;
  logic resetn;
  logic resolutionSelectLo;
  logic resolutionSelectHi;
  logic eepromDisableStrap;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [7:0] regRdata;
  logic [17:0] pixelDataOut;
  logic pixelValid;
  logic inputLost;
  logic [1:0] modeSel;
  logic useEnable;
  logic [17:0] pixelWord;
  int errors;
  int checkCount;

  prgbc_link_if prgbc_link_if_i ();
  prgbc_video_source prgbc_video_source_i (.core_clk(core_clk),
    .resetn(resetn), .modeSel(modeSel), .useEnable(useEnable),
    .pixelWord(pixelWord), .link(prgbc_link_if_i.source));
  prgbc_capture prgbc_capture_i (.core_clk(core_clk), .resetn(resetn),
    .resolutionSelectLo(resolutionSelectLo),
    .resolutionSelectHi(resolutionSelectHi),
    .eepromDisableStrap(eepromDisableStrap), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .pixelDataOut(pixelDataOut),
    .pixelValid(pixelValid), .inputLost(inputLost),
    .link(prgbc_link_if_i.capture));
  prgbc_link_checker prgbc_link_checker_i (.core_clk(core_clk),
    .resetn(resetn), .pixelClockIn(prgbc_link_if_i.pixelClockIn),
    .lineSyncN(prgbc_link_if_i.lineSyncN),
    .frameSyncN(prgbc_link_if_i.frameSyncN),
    .enableEdge(prgbc_link_if_i.enableEdge),
    .redIn(prgbc_link_if_i.redIn), .greenIn(prgbc_link_if_i.greenIn),
    .blueIn(prgbc_link_if_i.blueIn));

  // 20 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task end_sim();
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checkCount++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask : chk

  // Leading edge wait keeps strobes from being set twice in one step
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : reg_wr

  task reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : reg_rd

  // Straps must be set before release, they are caught only in the three cycles after it
  task do_reset(input logic strap, input logic [1:0] m, input logic en);
    @(posedge core_clk);
    resetn <= 1'b0;
    eepromDisableStrap <= strap;
    resolutionSelectLo <= m[0];
    resolutionSelectHi <= m[1];
    modeSel <= m;
    useEnable <= en;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : do_reset

  task test_fixed();
    logic [7:0] d;
    do_reset(1'b1, 2'h1, 1'b0);
    reg_rd(8'h08, d);
    chk("hstart", 16'h00C2, {8'h00, d});
    reg_rd(8'h09, d);
    chk("vstart", 16'h0023, {8'h00, d});
    eepromDisableStrap <= 1'b0;
    reg_wr(8'h08, 8'h55);
    reg_rd(8'h08, d);
    chk("hstartKept", 16'h00C2, {8'h00, d});
    reg_rd(8'h32, d);
    chk("ready", 16'h0001, {15'h0000, d[7]});
    chk("lostBit", 16'h0001, {15'h0000, d[1]});
    chk("lostPin", 16'h0001, {15'h0000, inputLost});
    reg_rd(8'h40, d);
    chk("unmapped", 16'h0000, {8'h00, d});
    $display("test_fixed done");
  endtask : test_fixed

  task test_eeprom();
    logic [7:0] d;
    do_reset(1'b0, 2'h0, 1'b0);
    reg_rd(8'h32, d);
    chk("readyLow", 16'h0000, {15'h0000, d[7]});
    reg_wr(8'h08, 8'h30);
    reg_rd(8'h08, d);
    chk("hstartProg", 16'h0030, {8'h00, d});
    reg_wr(8'h09, 8'h1C);
    reg_rd(8'h09, d);
    chk("vstartProg", 16'h001C, {8'h00, d});
    $display("test_eeprom done");
  endtask : test_eeprom

  // Counts one whole line of pixel clocks on the wire
  task test_lines();
    logic [10:0] act[4] = '{11'h320, 11'h190, 11'h1E0, 11'h1E0};
    logic [10:0] pmin[4] = '{11'h400, 11'h1EB, 11'h23B, 11'h24D};
    logic [10:0] pmax[4] = '{11'h440, 11'h233, 11'h286, 11'h2AD};
    logic [10:0] per;
    logic [10:0] en;
    logic [10:0] sw;
    logic pcQ;
    logic wentHigh;
    int n;
    for (int m = 0; m < 4; m++)
    begin
      do_reset(1'b1, 2'(m), 1'b1);
      n = 0;
      while (prgbc_link_if_i.lineSyncN !== 1'b0 && n < 12000)
      begin
        @(negedge core_clk);
        n++;
      end
      per = 11'h000;
      en = 11'h000;
      sw = 11'h000;
      wentHigh = 1'b0;
      pcQ = prgbc_link_if_i.pixelClockIn;
      while (!(wentHigh && prgbc_link_if_i.lineSyncN === 1'b0) && n < 24000)
      begin
        @(negedge core_clk);
        n++;
        wentHigh = wentHigh || prgbc_link_if_i.lineSyncN;
        if (prgbc_link_if_i.pixelClockIn && !pcQ)
        begin
          per++;
          en = en + 11'(prgbc_link_if_i.enableEdge);
          sw = sw + 11'(!prgbc_link_if_i.lineSyncN);
        end
        pcQ = prgbc_link_if_i.pixelClockIn;
      end
      if (n >= 24000)
      begin
        errors++;
        end_sim();
      end
      chk("periodOk", 16'h0001,
        {15'h0000, per >= pmin[m] && per <= pmax[m]});
      chk("enableWidth", {5'h00, act[m]}, {5'h00, en});
      chk("syncWidthOk", 16'h0001, {15'h0000, sw >= 11'h005});
      $display("test_lines mode %0d done", m);
    end
  endtask : test_lines

  // Programmed starts: first pixel place and pixel count of one line
  task test_capture();
    logic pcQ;
    logic hsQ;
    logic done;
    logic [10:0] pos;
    logic [10:0] first;
    logic [10:0] cnt;
    int n;
    do_reset(1'b0, 2'h1, 1'b0);
    reg_wr(8'h09, 8'h01);
    reg_wr(8'h08, 8'h14);
    pcQ = 1'b1;
    hsQ = 1'b0;
    done = 1'b0;
    pos = 11'h000;
    first = 11'h000;
    cnt = 11'h000;
    n = 0;
    while (!done && n < 12000)
    begin
      @(negedge core_clk);
      n++;
      // Pixel index counted from the line sync leading edge
      if (hsQ && !prgbc_link_if_i.lineSyncN)
      begin
        done = cnt != 11'h000;
        pos = 11'h7FF;
      end
      else if (prgbc_link_if_i.pixelClockIn && !pcQ)
        pos++;
      if (pixelValid === 1'b1)
      begin
        if (cnt == 11'h000)
        begin
          first = pos;
          chk("red", 16'h002A, {10'h000, pixelDataOut[17:12]});
          chk("green", 16'h0017, {10'h000, pixelDataOut[11:6]});
          chk("blue", 16'h0003, {10'h000, pixelDataOut[5:0]});
        end
        cnt++;
      end
      hsQ = prgbc_link_if_i.lineSyncN;
      pcQ = prgbc_link_if_i.pixelClockIn;
    end
    if (!done)
    begin
      errors++;
      end_sim();
    end
    chk("firstPixel", 16'h0014, {5'h00, first});
    chk("pixelCount", 16'h0190, {5'h00, cnt});
    $display("test_capture done");
  endtask : test_capture

  // Main sequence
  initial
  begin
    errors = 0;
    checkCount = 0;
    resetn <= 1'b0;
    resolutionSelectLo <= 1'b0;
    resolutionSelectHi <= 1'b0;
    eepromDisableStrap <= 1'b1;
    regAddr <= 8'h00;
    regWdata <= 8'h00;
    regWrite <= 1'b0;
    regRead <= 1'b0;
    modeSel <= 2'h0;
    useEnable <= 1'b0;
    pixelWord <= 18'h2A5C3;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    test_fixed();
    test_eeprom();
    test_capture();
    test_lines();
    end_sim();
  end
endmodule : tb_top
